// >>> hdl/smpi_consts.vh
// constants for the secure memory pin interface
`ifndef SMPI_CONSTS_VH
`define SMPI_CONSTS_VH

// ------------------------------------------------------------------
// memory geometry
// ------------------------------------------------------------------
`define SMPI_AW           8
`define SMPI_DW           8
`define SMPI_DEPTH        256

// ------------------------------------------------------------------
// asynchronous answer-to-reset timing and framing
// ------------------------------------------------------------------
`define SMPI_EBP_CYCLES   9'd372
`define SMPI_EBP_LAST     (`SMPI_EBP_CYCLES - 9'd1)
`define SMPI_FRAME_LAST   4'hB
`define SMPI_ATR_BASE     8'h00
`define SMPI_ATR_LAST     3'h7
`define SMPI_LOAD_WAIT    2'h2

// ------------------------------------------------------------------
// synchronous link: first byte is {device address, command}
// ------------------------------------------------------------------
`define SMPI_CMD_WRITE    4'h0
`define SMPI_CMD_RDRAND   4'h1
`define SMPI_DEV_NONE     4'h0
`define SMPI_BIT_LAST     3'h7
`define SMPI_IDX_CMD      2'h0
`define SMPI_IDX_ADDR     2'h1
`define SMPI_IDX_DATA     2'h2

// link clock limit: 1 MHz serial clock against a 25 MHz core clock
`define SMPI_SCL_MAX_HZ   1000000
`define SMPI_CLK_HZ       25000000

`endif

// >>> hdl/smpi_mem.v
// byte memory holding user data and the answer-to-reset bytes
`timescale 1ns/1ps
`include "smpi_consts.vh"

module smpi_mem (
   input  wire                  i_clk,
   input  wire                  i_we,
   input  wire [`SMPI_AW-1:0]   i_waddr,
   input  wire [`SMPI_DW-1:0]   i_wdata,
   input  wire [`SMPI_AW-1:0]   i_raddr,
   output reg  [`SMPI_DW-1:0]   o_rdata
);

   reg [`SMPI_DW-1:0] mem [0:`SMPI_DEPTH-1];

   // ---------------------------------------------------------------
   // write port and registered read port
   // ---------------------------------------------------------------
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end

endmodule

// >>> hdl/smpi_top.v
// pin front end: two-wire serial slave and answer-to-reset sender
`timescale 1ns/1ps
`include "smpi_consts.vh"

// Contract
// - each answer-to-reset bit lasts 372 carrier clock cycles.
// - sync data sampled on clock rise, output changed on clock fall.
// - reset sequence in async mode sends the 64-bit answer-to-reset bytes.
// - reset pin low idles the sync slave and answer sender; the async mode flag and memory keep their values.
// - reset pin is weakly pulled high inside the device.
// - no answer-to-reset is produced in synchronous operation.
// - data line only pulled low or released, never driven high.
// - up to fifteen devices, each selected by its own address.
// - random read streams successive bytes while the host acknowledges each one.
// - serial clock runs at up to 1 MHz.
module smpi_top (
   input  wire       i_clk,
   input  wire       i_resetn,
   input  wire       i_scl,
   input  wire       i_sda,
   input  wire       i_rst_pin,
   input  wire [3:0] i_dev_addr,
   output wire       o_sda_out,
   output reg        o_sda_oe,
   output wire       o_rst_pullup_oe,
   output reg        o_async_mode
);

   localparam [2:0] S_IDLE = 3'd0;
   localparam [2:0] S_RX   = 3'd1;
   localparam [2:0] S_ACK  = 3'd2;
   localparam [2:0] S_TX   = 3'd3;
   localparam [2:0] S_MACK = 3'd4;
   reg  [1:0]          scl_sy, sda_sy, rst_sy;
   reg                 scl_d, sda_d, rst_d;
   reg  [2:0]          state, bitcnt, atr_byte;
   reg                 byte_full, ack_ok, rd_mode, we, twi_low;
   reg  [1:0]          byte_idx, atr_wait;
   reg  [7:0]          shreg, txsh, wdata;
   reg  [`SMPI_AW-1:0] addr, waddr;
   reg                 atr_busy, atr_low;
   reg  [3:0]          atr_bit;
   reg  [8:0]          ebp_cnt;
   reg  [11:0]         frame;
   wire [7:0]          rdata;
   wire [`SMPI_AW-1:0] raddr;
   wire                scl_s, sda_s, rst_s, rst_rise;
   wire                scl_rise, scl_fall, start_c, stop_c;

   // ---------------------------------------------------------------
   // pin synchronisers and edge detection
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         scl_sy <= 2'b11;
         sda_sy <= 2'b11;
         rst_sy <= 2'b11;   // idle as pulled high
         scl_d  <= 1'b1;
         sda_d  <= 1'b1;
         rst_d  <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[0], i_scl};
         sda_sy <= {sda_sy[0], i_sda};
         rst_sy <= {rst_sy[0], i_rst_pin};
         scl_d  <= scl_sy[1];
         sda_d  <= sda_sy[1];
         rst_d  <= rst_sy[1];
      end
   end

   assign scl_s    = scl_sy[1];
   assign sda_s    = sda_sy[1];
   assign rst_s    = rst_sy[1];
   assign scl_rise = scl_s & ~scl_d;   // 1 MHz leaves 12+ clk a phase
   assign scl_fall = ~scl_s & scl_d;
   assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;
   assign rst_rise = rst_s & ~rst_d;

   // constant pin controls: weak reset pull-up, open-drain data value
   assign o_rst_pullup_oe = 1'b1;
   assign o_sda_out = 1'b0;

   // ---------------------------------------------------------------
   // async mode flag, kept across reset pin low
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_async_mode <= 1'b0;
      end else if (rst_rise) begin
         o_async_mode <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // two-wire slave
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state    <= S_IDLE;
         bitcnt   <= 3'h0;
         byte_full<= 1'b0;
         ack_ok   <= 1'b0;
         rd_mode  <= 1'b0;
         byte_idx <= `SMPI_IDX_CMD;
         shreg    <= 8'h00;
         txsh     <= 8'h00;
         addr     <= {`SMPI_AW{1'b0}};
         we       <= 1'b0;
         waddr    <= {`SMPI_AW{1'b0}};
         wdata    <= 8'h00;
         twi_low  <= 1'b0;
      end else if (!rst_s || o_async_mode) begin
         state    <= S_IDLE;
         bitcnt   <= 3'h0;
         byte_full<= 1'b0;
         ack_ok   <= 1'b0;
         rd_mode  <= 1'b0;
         byte_idx <= `SMPI_IDX_CMD;
         we       <= 1'b0;
         twi_low  <= 1'b0;
      end else begin
         we <= 1'b0;
         if (stop_c) begin
            state   <= S_IDLE;
            twi_low <= 1'b0;
         end else if (start_c) begin
            state     <= S_RX;
            bitcnt    <= 3'h0;
            byte_full <= 1'b0;
            byte_idx  <= `SMPI_IDX_CMD;
            rd_mode   <= 1'b0;
            twi_low   <= 1'b0;
         end else if (scl_rise) begin
            // sample on the rising edge
            case (state)
               S_RX: begin
                  shreg     <= {shreg[6:0], sda_s};
                  bitcnt    <= bitcnt + 3'h1;
                  byte_full <= (bitcnt == `SMPI_BIT_LAST);
               end
               S_TX: begin
                  bitcnt    <= bitcnt + 3'h1;
                  byte_full <= (bitcnt == `SMPI_BIT_LAST);
               end
               S_MACK: begin
                  ack_ok <= ~sda_s;
                  if (sda_s) begin
                     state <= S_IDLE;                   // host ends read
                  end
               end
               default: begin
               end
            endcase
         end else if (scl_fall) begin
            // change output on the falling edge
            case (state)
               S_RX: begin
                  if (byte_full) begin
                     byte_full <= 1'b0;
                     if (byte_idx == `SMPI_IDX_CMD) begin
                        if (shreg[7:4] == i_dev_addr &&
                            i_dev_addr != `SMPI_DEV_NONE) begin
                           state   <= S_ACK;
                           twi_low <= 1'b1;
                           rd_mode <= (shreg[3:0] == `SMPI_CMD_RDRAND);
                           byte_idx <= `SMPI_IDX_ADDR;
                        end else begin
                           state <= S_IDLE;
                        end
                     end else if (byte_idx == `SMPI_IDX_ADDR) begin
                        addr     <= shreg;
                        state    <= S_ACK;
                        twi_low  <= 1'b1;
                        byte_idx <= `SMPI_IDX_DATA;
                     end else begin
                        we      <= 1'b1;
                        waddr   <= addr;
                        wdata   <= shreg;
                        addr    <= addr + 8'h01;
                        state   <= S_ACK;
                        twi_low <= 1'b1;
                     end
                  end
               end
               S_ACK: begin
                  bitcnt <= 3'h0;
                  if (rd_mode && byte_idx == `SMPI_IDX_DATA) begin
                     state   <= S_TX;
                     txsh    <= {rdata[6:0], 1'b0};
                     twi_low <= ~rdata[7];
                     addr    <= addr + 8'h01;
                  end else begin
                     state   <= S_RX;
                     twi_low <= 1'b0;
                  end
               end
               S_TX: begin
                  if (byte_full) begin
                     byte_full <= 1'b0;
                     state     <= S_MACK;
                     twi_low   <= 1'b0;
                  end else begin
                     txsh    <= {txsh[6:0], 1'b0};
                     twi_low <= ~txsh[7];
                  end
               end
               S_MACK: begin
                  if (ack_ok) begin
                     ack_ok  <= 1'b0;
                     bitcnt  <= 3'h0;
                     state   <= S_TX;
                     txsh    <= {rdata[6:0], 1'b0};
                     twi_low <= ~rdata[7];
                     addr    <= addr + 8'h01;           // wraps at top
                  end
               end
               default: begin
                  twi_low <= 1'b0;
               end
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // answer-to-reset sender, timed by carrier rising edges
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         atr_busy <= 1'b0;
         atr_byte <= 3'h0;
         atr_bit  <= 4'h0;
         ebp_cnt  <= 9'h000;
         atr_wait <= 2'h0;
         frame    <= 12'hFFF;
         atr_low  <= 1'b0;
      end else if (!rst_s) begin
         atr_busy <= 1'b0;
         atr_wait <= 2'h0;
         atr_low  <= 1'b0;
      end else if (rst_rise) begin
         atr_busy <= 1'b1;
         atr_byte <= 3'h0;
         atr_bit  <= 4'h0;
         ebp_cnt  <= 9'h000;
         atr_wait <= `SMPI_LOAD_WAIT;
      end else if (atr_busy && o_async_mode) begin
         if (atr_wait != 2'h0) begin
            atr_wait <= atr_wait - 2'h1;
            if (atr_wait == 2'h1) begin
               // stop bits, even parity, data lsb first, start bit
               frame   <= {2'b11, ^rdata, rdata, 1'b0};
               atr_low <= 1'b1;
               atr_bit <= 4'h0;
               ebp_cnt <= 9'h000;
            end
         end else if (scl_rise) begin
            if (ebp_cnt == `SMPI_EBP_LAST) begin
               ebp_cnt <= 9'h000;
               if (atr_bit == `SMPI_FRAME_LAST) begin
                  atr_low <= 1'b0;
                  if (atr_byte == `SMPI_ATR_LAST) begin
                     atr_busy <= 1'b0;
                  end else begin
                     atr_byte <= atr_byte + 3'h1;
                     atr_wait <= `SMPI_LOAD_WAIT;
                  end
               end else begin
                  atr_bit <= atr_bit + 4'h1;
                  atr_low <= ~frame[atr_bit + 4'h1];
               end
            end else begin
               ebp_cnt <= ebp_cnt + 9'h001;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // shared open-drain data pin and memory read address
   // ---------------------------------------------------------------
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sda_oe <= 1'b0;
      end else begin
         o_sda_oe <= o_async_mode ? atr_low : twi_low;
      end
   end

   assign raddr = atr_busy ? (`SMPI_ATR_BASE + {5'h00, atr_byte}) : addr;
   smpi_mem u_mem (
      .i_clk   (i_clk),   .i_we    (we),
      .i_waddr (waddr),   .i_wdata (wdata),
      .i_raddr (raddr),   .o_rdata (rdata)
   );
endmodule

// >>> verif/smpi_chk.sv
// concurrent checks on the pins of the secure memory front end
`timescale 1ns/1ps
module smpi_chk (
   input wire       i_clk,
   input wire       i_resetn,
   input wire       i_scl,
   input wire       i_sda,
   input wire       i_rst_pin,
   input wire [3:0] i_dev_addr,
   input wire       o_sda_out,
   input wire       o_sda_oe,
   input wire       o_rst_pullup_oe,
   input wire       o_async_mode
);
   reg       scl_q;
   reg       oe_q;
   reg [9:0] rises;

   // carrier rises since the data line last changed, saturating
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         scl_q <= 1'h1;
         oe_q  <= 1'h0;
         rises <= 10'h000;
      end else begin
         scl_q <= i_scl;
         oe_q  <= o_sda_oe;
         if (o_sda_oe != oe_q)
            rises <= 10'h000;
         else if (i_scl && !scl_q && rises != 10'h3FF)
            rises <= rises + 10'h001;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence pin_low_run;
      !i_rst_pin [*5];
   endsequence
   sequence idle_high_run;
      (i_scl && i_rst_pin) [*8];
   endsequence

   sda_open_drain_a: assert property (o_sda_out == 1'h0)
      else $error("data line driven high");
   pullup_on_a: assert property (o_rst_pullup_oe == 1'h1)
      else $error("reset pin pull-up off");
   async_enter_a: assert property ($rose(o_async_mode) |-> i_rst_pin)
      else $error("async mode entered with reset pin low");
   flag_kept_a: assert property (!$fell(o_async_mode))
      else $error("async flag lost");
   pin_reset_a: assert property (pin_low_run |-> !o_sda_oe)
      else $error("data line driven during pin reset");
   addr_zero_a: assert property (
      i_dev_addr == 4'h0 && !o_async_mode |-> !o_sda_oe)
      else $error("address zero answered");
   idle_quiet_a: assert property (
      !o_async_mode ##0 idle_high_run |=> $stable(o_sda_oe))
      else $error("sync output without clocking");
   sync_edge_a: assert property (!o_async_mode && $changed(o_sda_oe)
      && i_rst_pin && $past(i_rst_pin, 5) |-> !i_scl && !$past(i_scl, 2))
      else $error("sync output changed outside low phase");
   ebp_length_a: assert property (
      o_async_mode && $past(o_async_mode, 8) && i_rst_pin
      && $changed(o_sda_oe) |-> rises >= 10'h173)
      else $error("bit period too short");
endmodule

// >>> verif/smpi_host.sv
// host model: two-wire master, reset pin driver and carrier source
`timescale 1ns/1ps
module smpi_host (
   input  wire i_clk,
   input  wire i_sda,
   output reg  o_scl,
   output reg  o_sda_oe,
   output reg  o_rst_low
);
   reg     car;
   integer k;

   // idle: clock high, both lines released
   initial begin
      o_scl = 1'h1;
      o_sda_oe = 1'h0;
      o_rst_low = 1'h0; // reset line released, pulled high by the device
      car = 1'h0;
   end

   // carrier of 320 ns, free phase, still while disabled
   initial begin
      #7;
      forever begin
         #160;
         if (car)
            o_scl = ~o_scl;
      end
   end

   task wt(input integer n);
      begin
         repeat (n) @(posedge i_clk);
         #2;
      end
   endtask

   task start;
      begin
         o_scl = 1'h1;
         wt(13);
         o_sda_oe = 1'h1;
         wt(13);
         o_scl = 1'h0;
      end
   endtask

   task stop;
      begin
         wt(6);
         o_sda_oe = 1'h1;
         wt(7);
         o_scl = 1'h1;
         wt(13);
         o_sda_oe = 1'h0;
         wt(13);
      end
   endtask

   // one clock of 26 core cycles, just under 1 MHz
   task bit_cyc(input b, output s);
      begin
         wt(6);
         o_sda_oe = ~b;
         wt(7);
         o_scl = 1'h1;
         wt(6);
         s = i_sda;
         wt(7);
         o_scl = 1'h0;
      end
   endtask

   // byte out msb first, then a ninth clock with the line released samples the ack
   task tx(input [7:0] b, output ack);
      reg s;
      begin
         for (k = 7; k >= 0; k = k - 1)
            bit_cyc(b[k], s);
         bit_cyc(1'h1, s);
         ack = ~s;
      end
   endtask

   task rx(input ack, output [7:0] b);
      reg s;
      begin
         for (k = 7; k >= 0; k = k - 1) begin
            bit_cyc(1'h1, s);
            b[k] = s;
         end
         bit_cyc(~ack, s);
      end
   endtask
endmodule

// >>> verif/tb_smpi_top.sv
// self-checking bench for the secure memory pin front end
`timescale 1ns/1ps
`include "smpi_consts.vh"
module tb_smpi_top;
   reg         i_clk;
   reg         i_resetn;
   reg  [3:0]  i_dev_addr;
   wire        scl_w;
   wire        sda_w;
   wire        rst_w;
   wire        host_oe;
   wire        host_rst;
   wire        o_sda_out;
   wire        o_sda_oe;
   wire        o_rst_pullup_oe;
   wire        o_async_mode;
   integer     err_count;
   integer     n_checks;
   integer     i;
   integer     n;
   reg  [19:0] seed;
   reg  [7:0]  atr [0:7];
   reg  [7:0]  rd;
   reg  [3:0]  dev;
   reg         ack;
   reg  [10:0] frame;

   // open-drain data line and reset pin, both pulled up
   assign sda_w = (o_sda_oe ? o_sda_out : 1'h1) & ~host_oe;
   assign rst_w = host_rst ? 1'h0 : o_rst_pullup_oe;

   smpi_top uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_scl(scl_w),
      .i_sda(sda_w), .i_rst_pin(rst_w), .i_dev_addr(i_dev_addr),
      .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
      .o_rst_pullup_oe(o_rst_pullup_oe), .o_async_mode(o_async_mode));
   smpi_host host (.i_clk(i_clk), .i_sda(sda_w), .o_scl(scl_w),
      .o_sda_oe(host_oe), .o_rst_low(host_rst));

   initial i_clk = 1'h0;
   always #20 i_clk = ~i_clk;

   function [19:0] lfsr(input [19:0] s);
      lfsr = {s[18:0], s[19] ^ s[16]};
   endfunction
   // parity and two stop bits that close a character
   function [2:0] tail(input [7:0] b);
      tail = {2'h3, ^b};
   endfunction

   task chk(input [7:0] got, input [7:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task end_sim;
      begin
         $display("checks=%0d errors=%0d", n_checks, err_count);
         if (err_count == 0 && n_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask

   initial begin
      #3000000;
      err_count = err_count + 1;
      end_sim;
   end

   initial begin
      i_resetn = 1'h0;
      i_dev_addr = 4'h0;
      err_count = 0;
      n_checks = 0;
      seed = 20'h14E9A;
      for (i = 0; i < 8; i = i + 1) begin
         seed = lfsr(seed);
         atr[i] = seed[7:0];
      end
      atr[0] = atr[0] | 8'h01; // lsb high so the start bit can be timed
      seed = lfsr(seed);
      dev = (seed[3:0] == 4'h0) ? 4'h9 : seed[3:0];
      repeat (12) @(posedge i_clk);
      #2;
      i_resetn = 1'h1;
      i_dev_addr = dev;
      host.wt(4);
      // load the answer bytes over the sync link
      host.start;
      host.tx({dev, `SMPI_CMD_WRITE}, ack);
      chk(ack, 8'h01);
      host.tx(`SMPI_ATR_BASE, ack);
      for (i = 0; i < 8; i = i + 1) begin
         host.tx(atr[i], ack);
         chk(ack, 8'h01);
      end
      host.stop;
      // another device, then the address that is never selected
      host.start;
      host.tx({dev + 4'h1, `SMPI_CMD_WRITE}, ack);
      chk(ack, 8'h00);
      host.stop;
      i_dev_addr = 4'h0;
      host.start;
      host.tx(8'h00, ack);
      chk(ack, 8'h00);
      host.stop;
      i_dev_addr = dev;
      // random read streams the bytes in order
      host.start;
      host.tx({dev, `SMPI_CMD_RDRAND}, ack);
      chk(ack, 8'h01);
      host.tx(`SMPI_ATR_BASE, ack);
      for (i = 0; i < 8; i = i + 1) begin
         host.rx(i < 7, rd);
         chk(rd, atr[i]);
      end
      host.stop;
      // reset pin pulse: quiet while low, answer after release
      host.o_rst_low = 1'h1;
      host.wt(20);
      chk(o_sda_oe, 8'h00);
      chk(o_async_mode, 8'h00);
      host.car = 1'h1;
      host.o_rst_low = 1'h0;
      n = 0;
      while (sda_w !== 1'h0 && n < 100) begin
         @(posedge i_clk);
         n = n + 1;
      end
      chk(n < 100, 8'h01);
      chk(o_async_mode, 8'h01);
      n = 0;
      while (sda_w === 1'h0 && n < 2000) begin
         @(posedge scl_w);
         n = n + 1;
      end
      chk(n >= 371 && n <= 373, 8'h01);
      repeat (186) @(posedge scl_w);
      for (i = 0; i < 11; i = i + 1) begin
         frame[i] = sda_w;
         repeat (372) @(posedge scl_w);
      end
      chk(frame[7:0], atr[0]);
      chk(frame[10:8], tail(atr[0]));
      chk(sda_w, 8'h00);
      // abort in mid-character releases the data line and keeps the mode flag
      host.wt(1);
      host.o_rst_low = 1'h1;
      host.wt(8);
      chk(o_sda_oe, 8'h00);
      chk(o_async_mode, 8'h01);
      host.car = 1'h0;
      i_resetn = 1'h0;
      host.wt(2);
      chk(o_async_mode, 8'h00);
      end_sim;
   end
endmodule

bind smpi_top smpi_chk chk (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_scl(i_scl), .i_sda(i_sda),
   .i_rst_pin(i_rst_pin), .i_dev_addr(i_dev_addr), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .o_rst_pullup_oe(o_rst_pullup_oe),
   .o_async_mode(o_async_mode)
);
